// ==== design/bsc_consts.svh ====
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define BSC_ADDR_CFG2      8'h27
`define BSC_CFG2_RESET     8'h00
`define BSC_BIT_FLUSH      7
`define BSC_BIT_WAKE_SRC   6
`define BSC_WM_MSB         5
`define BSC_WM_LSB         0

// ****************************************
// buffer mode codes
// ****************************************
`define BSC_MODE_OFF       2'h0
`define BSC_MODE_STREAM    2'h1
`define BSC_MODE_STOP      2'h2
`define BSC_MODE_TRIG      2'h3

// ****************************************
// depth and counter limits
// ****************************************
`define BSC_DEPTH          6'h20
`define BSC_GATE_MAX       5'h1F

`endif

// ==== design/bsc_pkg.sv ====
package bsc_pkg;

   // trigger mode progress
   typedef enum logic [1:0] {
      trg_armed,
      trg_collect,
      trg_hold
   } bsc_trig_t;

   // auto wake/sleep power state
   typedef enum logic {
      pwr_wake,
      pwr_sleep
   } bsc_power_t;

endpackage : bsc_pkg

// ==== design/bsc_sleep_if.sv ====
`timescale 1ns/1ps

interface bsc_sleep_if;
   logic        odr_tick;
   logic        run;
   logic        restart;
   logic [15:0] limit;
   logic        expired;

   modport ctrl (
      output odr_tick,
      output run,
      output restart,
      output limit,
      input  expired
   );

   modport timer (
      input  odr_tick,
      input  run,
      input  restart,
      input  limit,
      output expired
   );
endinterface : bsc_sleep_if

// ==== design/bsc_sleep_timer.sv ====
`timescale 1ns/1ps

module bsc_sleep_timer (
   // clock and reset
   input wire logic   clk_sys,
   input wire logic   nrst,
   // control side
   bsc_sleep_if.timer tm
);
   import bsc_pkg::*;

   logic [15:0] ticks;
   logic [15:0] next_ticks;
   logic        hit;

   // a zero limit means auto-sleep is off, so it never expires
   assign hit = tm.odr_tick && (tm.limit != 16'h0000) && (ticks >= tm.limit - 16'h0001);

   always_comb begin
      next_ticks = ticks;
      if (tm.restart || !tm.run) begin
         next_ticks = 16'h0000;
      end else if (hit) begin
         next_ticks = 16'h0000;
      end else if (tm.odr_tick) begin
         next_ticks = ticks + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ticks <= 16'h0000;
      end else begin
         ticks <= next_ticks;
      end
   end

   // restart in the same cycle cancels the expiry
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tm.expired <= 1'b0;
      end else begin
         tm.expired <= hit && tm.run && !tm.restart;
      end
   end

endmodule : bsc_sleep_timer

// ==== design/bsc_sample_buffer_ctrl.sv ====
`timescale 1ns/1ps
`include "bsc_consts.svh"


module bsc_sample_buffer_ctrl (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // register port from the serial interface
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // configuration held in other registers
   input  wire logic [1:0]  buf_mode,
   input  wire logic        buf_gate,
   input  wire logic [15:0] autosleep_count,
   // sample path
   input  wire logic        sample_push,
   input  wire logic        sample_pop,
   output logic             sample_accept,
   output logic             sample_discard,
   output logic      [5:0]  sample_count,
   // events from the rest of the device
   input  wire logic        odr_tick,
   input  wire logic        trigger_evt,
   input  wire logic        wake_evt,
   input  wire logic        ext_flush,
   input  wire logic        gate_sample,
   input  wire logic        gate_overrun,
   // status
   output logic             watermark_flag,
   output logic             overflow_flag,
   output logic             gate_err,
   output logic      [4:0]  gate_cnt,
   output logic             flush_active,
   output logic             power_sleep,
   output logic             trig_full
);
   import bsc_pkg::*;

   // ****************************************
   // register decode
   // ****************************************
   function automatic logic cfg2_hit(input logic [7:0] addr);
      cfg2_hit = (addr == `BSC_ADDR_CFG2);
   endfunction : cfg2_hit

   logic       flush_bit;
   logic       wake_src_en;
   logic [5:0] watermark_level;
   logic       cfg2_wr;

   assign cfg2_wr = reg_wr && cfg2_hit(reg_addr);

   // the flush bit lives for exactly one cycle and then drops
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flush_bit <= 1'b0;
      end else begin
         flush_bit <= cfg2_wr && reg_wdata[`BSC_BIT_FLUSH];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wake_src_en     <= 1'b0;
         watermark_level <= 6'h00;
      end else if (cfg2_wr) begin
         wake_src_en     <= reg_wdata[`BSC_BIT_WAKE_SRC];
         watermark_level <= reg_wdata[`BSC_WM_MSB:`BSC_WM_LSB];
      end
   end

   // flush bit is masked so a read can never show it high
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= `BSC_CFG2_RESET;
      end else if (reg_rd) begin
         if (cfg2_hit(reg_addr)) begin
            reg_rdata <= {1'b0, wake_src_en, watermark_level};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // ****************************************
   // flush sources
   // ****************************************
   logic [1:0] mode_q;
   logic       mode_off_edge;
   logic       sleep_entry;
   logic       flush_now;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mode_q <= `BSC_MODE_OFF;
      end else begin
         mode_q <= buf_mode;
      end
   end

   assign mode_off_edge = (buf_mode == `BSC_MODE_OFF) && (mode_q != `BSC_MODE_OFF);

   // going to sleep flushes unless gating holds the data; triggered mode always flushes
   assign flush_now = flush_bit
                    || mode_off_edge
                    || ext_flush
                    || (sleep_entry && (!buf_gate || (buf_mode == `BSC_MODE_TRIG)));
   assign flush_active = flush_now;

   // ****************************************
   // occupancy and triggered mode
   // ****************************************
   bsc_trig_t  trig_state;
   bsc_trig_t  next_trig;
   logic [5:0] next_count;
   logic       push_ok;
   logic       pop_ok;
   logic       ovf_evt;
   logic       pretrig_cap;
   logic       emptied;

   assign pop_ok = sample_pop && (sample_count != 6'h00);
   assign emptied = pop_ok && (sample_count == 6'h01) && !sample_push;

   // before the trigger the oldest sample makes room once the watermark is reached
   assign pretrig_cap = (buf_mode == `BSC_MODE_TRIG) && (trig_state == trg_armed)
                      && (watermark_level != 6'h00)
                      && (sample_count >= watermark_level);

   always_comb begin
      push_ok        = 1'b0;
      sample_discard = 1'b0;
      ovf_evt        = 1'b0;
      if (sample_push && !flush_now) begin
         case (buf_mode)
            `BSC_MODE_STREAM: begin
               if (sample_count == `BSC_DEPTH && !pop_ok) begin
                  sample_discard = 1'b1;
                  ovf_evt        = 1'b1;
               end
               push_ok = 1'b1;
            end
            `BSC_MODE_STOP: begin
               push_ok = (sample_count != `BSC_DEPTH) || pop_ok;
               ovf_evt = !push_ok;
            end
            `BSC_MODE_TRIG: begin
               if (trig_state == trg_hold) begin
                  push_ok = 1'b0;
               end else if (pretrig_cap && !pop_ok) begin
                  push_ok        = 1'b1;
                  sample_discard = 1'b1;
               end else begin
                  push_ok = (sample_count != `BSC_DEPTH) || pop_ok;
               end
            end
            default: begin
               push_ok = 1'b0;
            end
         endcase
      end
   end

   assign sample_accept = push_ok;

   always_comb begin
      next_count = sample_count;
      if (flush_now) begin
         next_count = 6'h00;
      end else if (push_ok && !sample_discard && !pop_ok) begin
         next_count = sample_count + 6'h01;
      end else if (pop_ok && !(push_ok && !sample_discard)) begin
         next_count = sample_count - 6'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sample_count <= 6'h00;
      end else begin
         sample_count <= next_count;
      end
   end

   // collection ends when full; emptying or flushing rearms
   always_comb begin
      next_trig = trig_state;
      if (flush_now || emptied || buf_mode != `BSC_MODE_TRIG) begin
         next_trig = trg_armed;
      end else begin
         case (trig_state)
            trg_armed: begin
               if (trigger_evt && power_sleep) begin
                  next_trig = trg_collect;
               end
            end
            trg_collect: begin
               if (next_count == `BSC_DEPTH) begin
                  next_trig = trg_hold;
               end
            end
            trg_hold: begin
               next_trig = trg_hold;
            end
            default: begin
               next_trig = trg_armed;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         trig_state <= trg_armed;
      end else begin
         trig_state <= next_trig;
      end
   end

   assign trig_full = (trig_state == trg_hold);

   // ****************************************
   // event flags
   // ****************************************
   logic ovf_set;

   assign ovf_set = ovf_evt || (trig_state == trg_collect && next_trig == trg_hold);

   // compare against the count that will stand next cycle so the flag never lags the count
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         watermark_flag <= 1'b0;
      end else begin
         watermark_flag <= (watermark_level != 6'h00)
                        && (next_count >= watermark_level);
      end
   end

   // a new overflow wins over a pop-clear in the same cycle; a flush clears regardless
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         overflow_flag <= 1'b0;
      end else if (ovf_set && !flush_now) begin
         overflow_flag <= 1'b1;
      end else if (flush_now || pop_ok) begin
         overflow_flag <= 1'b0;
      end
   end

   // ****************************************
   // gate error and gate counter
   // ****************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gate_err <= 1'b0;
      end else if (gate_overrun) begin
         gate_err <= 1'b1;
      end else if (flush_now || emptied) begin
         gate_err <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gate_cnt <= 5'h00;
      end else if (flush_now || emptied) begin
         gate_cnt <= 5'h00;
      end else if (gate_sample && gate_cnt != `BSC_GATE_MAX) begin
         gate_cnt <= gate_cnt + 5'h01;
      end
   end

   // ****************************************
   // auto wake/sleep
   // ****************************************
   bsc_sleep_if sl ();
   bsc_power_t  power;
   logic        src_effective;
   logic        flags_cleared;

   bsc_sleep_timer u_bsc_sleep_timer (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .tm      (sl.timer)
   );

   assign src_effective = wake_src_en
                        && (buf_mode == `BSC_MODE_STREAM || buf_mode == `BSC_MODE_STOP);

   // host service of a pending flag counts as activity only when the option is live
   assign flags_cleared = (watermark_flag || overflow_flag) && (flush_bit || pop_ok);

   assign sl.odr_tick = odr_tick;
   assign sl.limit    = autosleep_count;
   assign sl.run      = (power == pwr_wake) && !trig_full;
   assign sl.restart  = wake_evt || (src_effective && flags_cleared);

   // expiry sleeps whether or not flags are pending; flags only delay it through restart
   assign sleep_entry = (power == pwr_wake) && sl.expired;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         power <= pwr_wake;
      end else begin
         case (power)
            pwr_wake: begin
               if (sleep_entry) begin
                  power <= pwr_sleep;
               end
            end
            pwr_sleep: begin
               if (wake_evt || (trigger_evt && buf_mode == `BSC_MODE_TRIG)) begin
                  power <= pwr_wake;
               end
            end
            default: begin
               power <= pwr_wake;
            end
         endcase
      end
   end

   assign power_sleep = (power == pwr_sleep);

endmodule : bsc_sample_buffer_ctrl

// ==== tb/bsc_sample_buffer_ctrl_chk.sv ====
`timescale 1ns/1ps
// ****
// buffer control checker
// ****
module bsc_sample_buffer_ctrl_chk (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       nrst,
   // register port
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // events
   input wire logic [1:0] buf_mode,
   input wire logic       ext_flush,
   input wire logic       gate_sample,
   input wire logic       gate_overrun,
   // status
   input wire logic [5:0] sample_count,
   input wire logic       watermark_flag,
   input wire logic       overflow_flag,
   input wire logic       gate_err,
   input wire logic [4:0] gate_cnt,
   input wire logic       flush_active
);
   logic [6:0] cfg;
   wire        cfg_hit = reg_addr == 8'h27;

   // shadow of the writable bits, so flag checks need no internal probe
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cfg <= 7'h00;
      end else if (reg_wr && cfg_hit) begin
         cfg <= reg_wdata[6:0];
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence s_flush_req;
      reg_wr && cfg_hit && reg_wdata[7];
   endsequence
   sequence s_emptied;
      sample_count == 6'h00 && !watermark_flag && !overflow_flag;
   endsequence

   property p_flush;
      s_flush_req |=> flush_active ##1 s_emptied;
   endproperty
   property p_self_clear;
      s_flush_req ##1 (!reg_wr && !ext_flush) |=> !flush_active || buf_mode == 2'h0;
   endproperty
   property p_gate;
      flush_active && !gate_overrun && !gate_sample |=> !gate_err && gate_cnt == 5'h00;
   endproperty
   property p_rd_msb;
      !reg_rdata[7];
   endproperty
   property p_rdback;
      reg_rd && cfg_hit && !reg_wr |=> reg_rdata == {1'b0, cfg};
   endproperty
   property p_wm_track;
      !$past(reg_wr) |-> watermark_flag == (cfg[5:0] != 6'h00 && sample_count >= cfg[5:0]);
   endproperty
   property p_wm_zero;
      cfg[5:0] == 6'h00 && !$past(reg_wr) |-> !watermark_flag;
   endproperty
   property p_off;
      $past(buf_mode) != 2'h0 && buf_mode == 2'h0 |-> ##[0:2] s_emptied;
   endproperty

   a_flush: assert property (p_flush) else $error("flush did not empty the buffer");
   a_self_clear: assert property (p_self_clear) else $error("flush bit stuck");
   a_gate: assert property (p_gate) else $error("gate state kept over flush");
   a_rd_msb: assert property (p_rd_msb) else $error("flush bit read high");
   a_rdback: assert property (p_rdback) else $error("config readback wrong");
   a_wm_track: assert property (p_wm_track) else $error("watermark flag off count");
   a_wm_zero: assert property (p_wm_zero) else $error("watermark flag at level zero");
   a_off: assert property (p_off) else $error("disable did not flush");
endmodule : bsc_sample_buffer_ctrl_chk

bind bsc_sample_buffer_ctrl bsc_sample_buffer_ctrl_chk u_bsc_sample_buffer_ctrl_chk (
   .clk_sys, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .buf_mode, .ext_flush,
   .gate_sample, .gate_overrun, .sample_count, .watermark_flag, .overflow_flag, .gate_err, .gate_cnt,
   .flush_active
);

// ==== tb/bsc_host_model.sv ====
`timescale 1ns/1ps
module bsc_host_model (
   // clock
   input  wire logic       clk_sys,
   // register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   // sample read-out
   output logic            sample_pop
);
   initial begin
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      sample_pop = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_rd = 1'b0;
      d      = reg_rdata;
   endtask : rd

   // removing a sample is how the host clears pending flags without a flush
   task automatic pop;
      sample_pop = 1'b1;
      @(posedge clk_sys);
      #1;
      sample_pop = 1'b0;
   endtask : pop
endmodule : bsc_host_model

// ==== tb/bsc_sample_buffer_ctrl_tb.sv ====
`timescale 1ns/1ps
module bsc_sample_buffer_ctrl_tb;
   import bsc_pkg::*;
   logic        clk_sys, nrst, reg_wr, reg_rd, sample_pop, buf_gate, sample_push, odr_tick;
   logic        trigger_evt, wake_evt, ext_flush, gate_sample, gate_overrun;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
   logic [1:0]  buf_mode;
   logic [15:0] autosleep_count;
   logic        sample_accept, sample_discard, watermark_flag, overflow_flag;
   logic        gate_err, flush_active, power_sleep, trig_full;
   logic [5:0]  sample_count;
   logic [4:0]  gate_cnt;
   int          miscompares, check_count;

   bsc_sample_buffer_ctrl u_bsc_sample_buffer_ctrl (
      .clk_sys, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .buf_mode, .buf_gate,
      .autosleep_count, .sample_push, .sample_pop, .sample_accept, .sample_discard, .sample_count,
      .odr_tick, .trigger_evt, .wake_evt, .ext_flush, .gate_sample, .gate_overrun, .watermark_flag,
      .overflow_flag, .gate_err, .gate_cnt, .flush_active, .power_sleep, .trig_full
   );
   bsc_host_model u_bsc_host_model (
      .clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sample_pop
   );

   // ****
   // helpers
   // ****
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic push(input int n);
      sample_push = 1'b1;
      cyc(n);
      sample_push = 1'b0;
   endtask : push

   // settle time covers the registered expiry and the state change after it
   task automatic tick;
      odr_tick = 1'b1;
      cyc(1);
      odr_tick = 1'b0;
      cyc(3);
   endtask : tick

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // ****
   // scenarios
   // ****
   task automatic t_reset_vals;
      u_bsc_host_model.rd(8'h27, rd_val);
      chk("cfg reset", rd_val, 8'h00);
      // let an edge pass so the read strobe is not dropped and raised in one step
      cyc(1);
      u_bsc_host_model.rd(8'h30, rd_val);
      chk("unmapped read", rd_val, 8'h00);
   endtask : t_reset_vals

   task automatic t_watermark;
      buf_mode = 2'h1;
      u_bsc_host_model.wr(8'h27, 8'h03);
      push(2);
      chk("wm below", watermark_flag, 8'h00);
      push(1);
      chk("wm reached", watermark_flag, 8'h01);
      u_bsc_host_model.pop;
      chk("wm after pop", watermark_flag, 8'h00);
      u_bsc_host_model.wr(8'h27, 8'h02);
      cyc(1);
      chk("wm equal", watermark_flag, 8'h01);
      u_bsc_host_model.wr(8'h27, 8'h00);
      cyc(1);
      chk("wm zero", watermark_flag, 8'h00);
   endtask : t_watermark

   task automatic t_flush;
      u_bsc_host_model.wr(8'h27, 8'h02);
      gate_sample = 1'b1;
      cyc(3);
      gate_sample  = 1'b0;
      gate_overrun = 1'b1;
      cyc(1);
      gate_overrun = 1'b0;
      chk("gate before", {gate_err, gate_cnt}, 8'h23);
      u_bsc_host_model.wr(8'h27, 8'h84);
      chk("flush pulse", flush_active, 8'h01);
      cyc(1);
      chk("flush over", flush_active, 8'h00);
      chk("count flushed", sample_count, 8'h00);
      chk("flags flushed", {watermark_flag, overflow_flag}, 8'h00);
      chk("gate flushed", {gate_err, gate_cnt}, 8'h00);
      u_bsc_host_model.rd(8'h27, rd_val);
      chk("flush bit read", rd_val, 8'h04);
   endtask : t_flush

   task automatic t_full_off;
      push(33);
      chk("full", {sample_count, overflow_flag, watermark_flag}, 8'h83);
      buf_mode = 2'h0;
      cyc(2);
      chk("off flush", {sample_count, watermark_flag, overflow_flag}, 8'h00);
   endtask : t_full_off

   task automatic t_trig;
      buf_mode = 2'h3;
      cyc(1);
      push(6);
      chk("pre-trigger cap", sample_count, 8'h04);
      chk("not full", trig_full, 8'h00);
      // a push at the cap is taken and the oldest sample dropped; released before the edge
      sample_push = 1'b1;
      #1;
      chk("cap accept discard", {sample_accept, sample_discard}, 8'h03);
      sample_push = 1'b0;
      buf_mode = 2'h0;
      cyc(2);
   endtask : t_trig

   task automatic t_sleep;
      buf_mode = 2'h1;
      for (int i = 0; i < 2; i++) begin
         u_bsc_host_model.wr(8'h27, (i == 1) ? 8'h41 : 8'h01);
         wake_evt = 1'b1;
         cyc(1);
         wake_evt = 1'b0;
         cyc(2);
         push(1);
         tick;
         u_bsc_host_model.pop;
         tick;
         chk("sleep after two ticks", power_sleep, (i == 1) ? 8'h00 : 8'h01);
         // leave the watermark flag pending so expiry in the second pass happens with a flag still set
         push(1);
         tick;
         chk("sleep at expiry", power_sleep, 8'h01);
      end
   endtask : t_sleep

   // ****
   // run
   // ****
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      {nrst, buf_gate, sample_push, odr_tick, trigger_evt} = '0;
      {wake_evt, ext_flush, gate_sample, gate_overrun} = '0;
      buf_mode        = 2'h0;
      autosleep_count = 16'h0002;
      miscompares     = 0;
      check_count     = 0;
      cyc(16);
      nrst = 1'b1;
      cyc(1);
      t_reset_vals;
      t_watermark;
      t_flush;
      t_full_off;
      t_trig;
      t_sleep;
      wrap_up;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      wrap_up;
   end
endmodule : bsc_sample_buffer_ctrl_tb
